// File: rtl/sbg_consts.svh
// sbg_consts.svh: offsets, field positions, reset values and divisors
// assumes byte addresses on a 32-bit APB, one register per aligned word
`ifndef SBG_CONSTS_SVH
`define SBG_CONSTS_SVH

// register byte addresses
`define SBG_CFG_OFS    8'h9C
`define SBG_CTRL_OFS   8'hA0
`define SBG_RELOAD_OFS 8'hA4
`define SBG_CNT_OFS    8'hA8

// reset values
`define SBG_CFG_RST    8'h20
`define SBG_CTRL_RST   8'h00
`define SBG_RELOAD_RST 8'h00
`define SBG_CNT_RST    8'h00

// configuration field positions
`define SBG_CFG_UPPER  7
`define SBG_CFG_FIXED  6
`define SBG_CFG_ORDER  5
`define SBG_CFG_RUN    4
`define SBG_CFG_DOUBLE 3
`define SBG_CFG_CKSEL  2
`define SBG_CFG_CKOE   1
`define SBG_CFG_TIMER  0

// divisors in system clocks or overflows, and the counter top value
`define SBG_DIV_SLOW   8'h0C
`define SBG_DIV_FAST   8'h04
`define SBG_M2_BASE    8'h40
`define SBG_M2_SLOW    8'hC0
`define SBG_M13_BASE   8'h20
`define SBG_CNT_MAX    8'hFF

`endif

// File: rtl/sbg_pkg.sv
// sbg_pkg.sv: types shared by the rate generator files
// assumes the field order of the configuration and control bytes
`default_nettype none

package sbg_pkg;

  // configuration byte, msb first
  typedef struct packed {
    logic mode_bit_upper;
    logic fixed_rate_select;
    logic data_order_or_width;
    logic generator_run;
    logic double_rate_enable;
    logic counter_clock_select;
    logic clock_out_enable;
    logic timer_mode_enable;
  } sbg_cfg_t;

  // serial control byte, msb first
  typedef struct packed {
    logic mode_bit_zero;
    logic mode_bit_one;
    logic addr_match_enable;
    logic receive_enable;
    logic ninth_transmit_bit;
    logic ninth_received_bit;
    logic transmit_flag;
    logic receive_flag;
  } sbg_ctrl_t;

  // serial operating modes
  typedef enum logic [2:0] {
    SBG_MODE_SHIFT,
    SBG_MODE_UART8,
    SBG_MODE_UART9_FIXED,
    SBG_MODE_UART9_VAR,
    SBG_MODE_SPI,
    SBG_MODE_RSVD
  } sbg_mode_t;

endpackage

`default_nettype wire

// File: rtl/sbg_divider.sv
// sbg_divider.sv: divides a step pulse by a live period, one-cycle tick out
// assumes period is at least one; a count at or past a shorter new period minus one wraps on the next step
`default_nettype none

module sbg_divider
  import sbg_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         step,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt;
  logic [W-1:0] top_val;
  logic         last;
  logic [W-1:0] next_cnt;

  // wrap at period minus one
  assign top_val  = period - W'(1);
  assign last     = cnt >= top_val;
  assign next_cnt = last ? '0 : cnt + W'(1);

  // count steps, tick on the wrap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= step & last;
      if (step) begin
        cnt <= next_cnt;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/sbg_top.sv
// sbg_top.sv: serial port rate generator, mode decode and spare timer
// assumes an APB master on SYS_CLK and a serial engine taking the ticks
//
// Functional notes
// - mode is three bits: shift, uart8, two uart9, spi, rest reserved
// - modes 0 and 4 shift at clock/12, or clock/4 with fixed rate set
// - mode 2 runs at clock/64 or clock/192, halved by double rate
// - outside timer mode data order bit one sends lsb first
// - in timer mode data order bit picks 8-bit reload or 16-bit timer
// - counter counts only while the run bit is set, else holds
// - double rate bit doubles the serial baud rate in modes 1, 2 and 3 only
// - counter clocked by clock/12, or every clock with select set
// - clock output drives the pin only while its enable is set
// - timer mode disables the port, frees the timer, adds pin detector
// - 8-bit up-counter reloads from reload register on each overflow
// - reload write with the generator stopped also loads the counter
// - running reload writes leave counter; counter writes leave reload
// - clock output toggles on every overflow, half the overflow rate
// - overflow goes to other peripherals whether port runs or idles
// - in timer mode each overflow sets the transmit flag
// - receive flag on pin fall, or rise when ninth received bit set
// - both flags raise the port interrupt, gated by tb8 and ren in timer mode only
// - power-down makes pin detection level based and may wake cpu
// - 16-bit timer mode counts timer 1 overflows
// - timer mode clock output toggles; its enable masks receive irq
// - modes 1 and 3 baud is 2^double/32 times overflow rate
// - configuration resets with only the data order bit set
//
// Decided for this implementation: the APB slave port.
`default_nettype none
`include "sbg_consts.svh"

module sbg_top
  import sbg_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_PIN,
  input  wire logic        TIMER1_OVF,
  input  wire logic        PWR_DOWN,
  input  wire logic        PORT_IRQ_EN,
  input  wire logic        ENG_TX_DONE,
  input  wire logic        ENG_RX_DONE,
  output logic             BAUD_TICK,
  output logic             PERIPH_CLK_TICK,
  output logic             GEN_CLK_OUT,
  output logic             GEN_CLK_OE_N,
  output logic      [2:0]  SERIAL_MODE,
  output logic             SERIAL_EN,
  output logic             LSB_FIRST,
  output logic             PORT_IRQ,
  output logic             WAKE_REQ
);

  sbg_cfg_t    cfg;
  sbg_ctrl_t   ctrl;
  logic [7:0]  reload;
  logic [7:0]  counter;

  // bus decode
  logic        setup;
  logic        acc_wr;
  logic        hit_cfg;
  logic        hit_ctrl;
  logic        hit_rl;
  logic        hit_cnt;
  logic        hit_any;
  logic        cfg_wr;
  logic        ctrl_wr;
  logic        rl_wr;
  logic        cnt_wr;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;

  assign setup    = PSEL & ~PENABLE;
  assign acc_wr   = PSEL & PENABLE & PREADY & PWRITE;
  assign hit_cfg  = PADDR == `SBG_CFG_OFS;
  assign hit_ctrl = PADDR == `SBG_CTRL_OFS;
  assign hit_rl   = PADDR == `SBG_RELOAD_OFS;
  assign hit_cnt  = PADDR == `SBG_CNT_OFS;
  assign hit_any  = hit_cfg | hit_ctrl | hit_rl | hit_cnt;
  assign cfg_wr   = acc_wr & hit_cfg;
  assign ctrl_wr  = acc_wr & hit_ctrl;
  assign rl_wr    = acc_wr & hit_rl;
  assign cnt_wr   = acc_wr & hit_cnt;
  assign wbyte    = PWDATA[7:0];

  // read mux, narrow data in the low byte
  assign rd_byte = hit_cfg  ? cfg :
                   hit_ctrl ? ctrl :
                   hit_rl   ? reload :
                   hit_cnt  ? counter : 8'h00;

  // one wait-free access: ready rises in the access phase
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= (setup & ~PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      PSLVERR <= setup & ~hit_any;
    end
  end

  // prescaler and counter clock source
  logic        pre12_tick;
  logic        tmr_mode;
  logic        wide_mode;
  logic        cnt_step;
  logic        cnt_tick;
  logic        ovf;
  logic [7:0]  next_counter;
  logic [7:0]  next_reload;

  sbg_divider #(
    .W      (8)
  ) u_pre12 (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .step   (1'b1),
    .period (`SBG_DIV_SLOW),
    .tick   (pre12_tick)
  );

  assign tmr_mode  = cfg.timer_mode_enable;
  assign wide_mode = tmr_mode & cfg.data_order_or_width;
  // cascade on timer 1 in wide mode, else clock or clock/12
  assign cnt_step  = wide_mode ? TIMER1_OVF
                   : (cfg.counter_clock_select | pre12_tick);
  assign cnt_tick  = cfg.generator_run & cnt_step;
  assign ovf       = cnt_tick & (counter == `SBG_CNT_MAX);

  // counter: own write, stopped reload write, reload, count
  assign next_counter = cnt_wr                       ? wbyte
                      : (rl_wr & ~cfg.generator_run) ? wbyte
                      : ovf                          ? reload
                      : cnt_tick ? counter + 8'h01 : counter;
  assign next_reload  = rl_wr ? wbyte : reload;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg     <= sbg_cfg_t'(`SBG_CFG_RST);
      reload  <= `SBG_RELOAD_RST;
      counter <= `SBG_CNT_RST;
    end else begin
      if (cfg_wr) begin
        cfg <= sbg_cfg_t'(wbyte);
      end
      reload  <= next_reload;
      counter <= next_counter;
    end
  end

  // overflow-driven outputs and the clock output enable
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      GEN_CLK_OUT     <= 1'b0;
      GEN_CLK_OE_N    <= 1'b1;
      PERIPH_CLK_TICK <= 1'b0;
    end else begin
      GEN_CLK_OUT     <= GEN_CLK_OUT ^ ovf;
      GEN_CLK_OE_N    <= ~cfg.clock_out_enable;
      PERIPH_CLK_TICK <= ovf;
    end
  end

  // mode decode
  logic [2:0]  mode_num;
  sbg_mode_t   mode;

  assign mode_num = {cfg.mode_bit_upper, ctrl.mode_bit_zero, ctrl.mode_bit_one};

  always_comb begin
    case (mode_num)
      3'h0: mode = SBG_MODE_SHIFT;
      3'h1: mode = SBG_MODE_UART8;
      3'h2: mode = SBG_MODE_UART9_FIXED;
      3'h3: mode = SBG_MODE_UART9_VAR;
      3'h4: mode = SBG_MODE_SPI;
      default: mode = SBG_MODE_RSVD;
    endcase
  end

  // rate dividers per mode group
  logic        is_shift;
  logic        is_fixed;
  logic        is_var;
  logic [7:0]  shift_period;
  logic [7:0]  m2_period;
  logic [7:0]  m13_period;
  logic        shift_tick;
  logic        m2_tick;
  logic        m13_tick;
  logic        next_baud;

  assign is_shift = (mode == SBG_MODE_SHIFT) | (mode == SBG_MODE_SPI);
  assign is_fixed = mode == SBG_MODE_UART9_FIXED;
  assign is_var   = (mode == SBG_MODE_UART8) | (mode == SBG_MODE_UART9_VAR);

  assign shift_period = cfg.fixed_rate_select ? `SBG_DIV_FAST
                      : `SBG_DIV_SLOW;
  assign m2_period    = (cfg.fixed_rate_select ? `SBG_M2_SLOW : `SBG_M2_BASE)
                      >> cfg.double_rate_enable;
  assign m13_period   = `SBG_M13_BASE >> cfg.double_rate_enable;

  sbg_divider #(
    .W      (8)
  ) u_shift (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .step   (1'b1),
    .period (shift_period),
    .tick   (shift_tick)
  );

  sbg_divider #(
    .W      (8)
  ) u_mode2 (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .step   (1'b1),
    .period (m2_period),
    .tick   (m2_tick)
  );

  // overflow divided by 32, or 16 at double rate
  sbg_divider #(
    .W      (8)
  ) u_mode13 (
    .clk    (SYS_CLK),
    .rst_n  (RST_N),
    .step   (ovf),
    .period (m13_period),
    .tick   (m13_tick)
  );

  // baud tick only while the serial function is enabled
  assign next_baud = ~tmr_mode & (is_shift ? shift_tick
                                 : is_fixed ? m2_tick
                                 : is_var & m13_tick);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      BAUD_TICK   <= 1'b0;
      SERIAL_MODE <= 3'h0;
      SERIAL_EN   <= 1'b1;
      LSB_FIRST   <= 1'b1;
    end else begin
      BAUD_TICK   <= next_baud;
      SERIAL_MODE <= mode_num;
      SERIAL_EN   <= ~tmr_mode;
      LSB_FIRST   <= cfg.data_order_or_width & ~tmr_mode;
    end
  end

  // receive pin synchroniser and change detector
  logic        rx_meta;
  logic        rx_sync;
  logic        rx_prev;
  logic        rx_edge;
  logic        rx_level;
  logic        rx_event;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= RX_PIN;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  assign rx_edge  = ctrl.ninth_received_bit ? (rx_sync & ~rx_prev)
                  : (rx_prev & ~rx_sync);
  assign rx_level = ctrl.ninth_received_bit ? rx_sync : ~rx_sync;
  assign rx_event = PWR_DOWN ? rx_level : rx_edge;

  // flag sources, hardware set beats software clear
  logic        ti_set;
  logic        ri_set;
  sbg_ctrl_t   ctrl_base;
  logic        next_ti;
  logic        next_ri;

  assign ti_set    = tmr_mode ? ovf : ENG_TX_DONE;
  assign ri_set    = tmr_mode ? (ctrl.receive_enable & rx_event)
                   : ENG_RX_DONE;
  assign ctrl_base = ctrl_wr ? sbg_ctrl_t'(wbyte) : ctrl;
  assign next_ti   = ctrl_base.transmit_flag | ti_set;
  assign next_ri   = ctrl_base.receive_flag | ri_set;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl <= sbg_ctrl_t'(`SBG_CTRL_RST);
    end else begin
      ctrl               <= ctrl_base;
      ctrl.transmit_flag <= next_ti;
      ctrl.receive_flag  <= next_ri;
    end
  end

  // port interrupt and wake request
  logic        irq_tmr;
  logic        next_irq;

  assign irq_tmr  = (ctrl.transmit_flag & ctrl.ninth_transmit_bit)
                  | (ctrl.receive_flag & ctrl.receive_enable
                     & ~cfg.clock_out_enable);
  assign next_irq = tmr_mode ? irq_tmr
                  : (ctrl.transmit_flag | ctrl.receive_flag);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PORT_IRQ <= 1'b0;
      WAKE_REQ <= 1'b0;
    end else begin
      PORT_IRQ <= next_irq;
      WAKE_REQ <= PWR_DOWN & PORT_IRQ_EN & next_irq;
    end
  end

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  run_hold_a: assert property (
    !cfg.generator_run && !cnt_wr && !rl_wr |=> $stable(counter))
    else $error("counter moved while stopped");

  reload_copy_a: assert property (
    ovf && !cnt_wr |=> counter == $past(reload))
    else $error("overflow did not reload counter");

  stop_load_a: assert property (
    rl_wr && !cfg.generator_run && !cnt_wr |=> counter == $past(wbyte))
    else $error("stopped reload write missed counter");

  cnt_write_a: assert property (
    cnt_wr && !rl_wr |=> $stable(reload) && counter == $past(wbyte))
    else $error("counter write disturbed reload");

  clk_toggle_a: assert property (
    ovf |=> GEN_CLK_OUT != $past(GEN_CLK_OUT))
    else $error("clock output missed toggle");

  clk_oe_a: assert property (
    $rose(cfg.clock_out_enable) |=> !GEN_CLK_OE_N ##1 !GEN_CLK_OE_N
      || !cfg.clock_out_enable)
    else $error("clock output enable not followed");

  tmr_ti_a: assert property (
    tmr_mode && ovf |=> ctrl.transmit_flag)
    else $error("timer overflow lost transmit flag");

  rx_fall_a: assert property (
    tmr_mode && ctrl.receive_enable && !ctrl.ninth_received_bit
      && !PWR_DOWN && rx_prev && !rx_sync |=> ctrl.receive_flag)
    else $error("falling edge lost receive flag");

  irq_mask_a: assert property (
    tmr_mode && cfg.clock_out_enable
      && !(ctrl.transmit_flag && ctrl.ninth_transmit_bit) |=> !PORT_IRQ)
    else $error("receive irq not masked");

endmodule

`default_nettype wire

// File: dv/sbg_remote_dev.sv
// sbg_remote_dev.sv: far serial device that drives the receive line
// assumes the bench asks for a line level; it is applied just after an edge
`default_nettype none

module sbg_remote_dev
  import sbg_pkg::*;
(
  input  wire logic clk,
  input  wire logic want_hi,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 1ns;

  // line idles high and only moves right after a rising edge
  initial rx_line = 1'b1;
  always @(posedge clk) begin
    rx_line <= want_hi;
  end
endmodule

`default_nettype wire

// File: dv/sbg_top_tb_top.sv
// sbg_top_tb_top.sv: self-checking bench for the rate generator and timer
// assumes sbg_top answers APB in one access cycle on a single 25 MHz clock
`default_nettype none
`include "sbg_consts.svh"

module sbg_top_tb_top
  import sbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        t1 = 1'b0, pdn = 1'b0, ien = 1'b0, want = 1'b1, last_err;
  logic        etx = 1'b0, erx = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000, prd;
  logic        rdy, serr, rx, bt, pt, co, oe_n, sen, lsb, irq, wk;
  logic [2:0]  smode;
  logic [7:0]  mdl [4];
  int          err_total = 0, checks_done = 0;
  // baud cases: mode, fixed rate, double rate, counter clock select
  int          tb [12] = '{16'h0001, 16'h0101, 16'h4101, 16'h4001, 16'h2001, 16'h2101,
                           16'h2011, 16'h2111, 16'h1001, 16'h3011, 16'h1000, 16'h5001};

  sbg_top uut (
    .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .RX_PIN(rx), .TIMER1_OVF(t1),
    .PWR_DOWN(pdn), .PORT_IRQ_EN(ien), .ENG_TX_DONE(etx), .ENG_RX_DONE(erx),
    .BAUD_TICK(bt), .PERIPH_CLK_TICK(pt), .GEN_CLK_OUT(co), .GEN_CLK_OE_N(oe_n),
    .SERIAL_MODE(smode), .SERIAL_EN(sen), .LSB_FIRST(lsb), .PORT_IRQ(irq), .WAKE_REQ(wk)
  );

  sbg_remote_dev remote (.clk(clk), .want_hi(want), .rx_line(rx));

  // free-running system clock
  always #20 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one APB transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    if (n == 16) err_total++;
    q = prd;
    last_err = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // register write that also updates the model register file
  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, `SBG_CFG_OFS + 8'(4 * i), 32'(d), q);
    if (i == 2 && mdl[0][4] == 1'b0) mdl[3] = d;
    mdl[i] = d;
  endtask

  task automatic rd(input int i);
    logic [31:0] q;
    apb(1'b0, `SBG_CFG_OFS + 8'(4 * i), 32'h0000_0000, q);
    chk(q, 32'(mdl[i]));
  endtask

  // cycles between two baud ticks, 600 when no tick comes
  task automatic per(output int p);
    int n;
    n = 0;
    while (bt !== 1'b1 && n < 600) begin
      n++;
      @(posedge clk);
    end
    @(posedge clk);
    p = 1;
    while (bt !== 1'b1 && p < 600) begin
      p++;
      @(posedge clk);
    end
  endtask

  function automatic int exp_p(input int e);
    int m, f, d, s;
    m = e >> 12;
    f = (e >> 8) & 1;
    d = (e >> 4) & 1;
    s = e & 1;
    if (m == 0 || m == 4) return f ? 4 : 12;
    if (m == 2) return (f ? 192 : 64) >> d;
    if (m == 1 || m == 3) return (32 >> d) * (s ? 1 : 12) * (256 - mdl[2]);
    return 600;
  endfunction

  // main sequence
  initial begin
    int p, k, j, m;
    logic lc;
    logic [31:0] q;
    void'($urandom(17));
    mdl = '{8'h20, 8'h00, 8'h00, 8'h00};
    cyc(8);
    rst_n <= 1'b1;
    cyc(2);
    chk(32'({sen, lsb, oe_n, co, irq}), 32'h0000_001C);
    rd(0);
    rd(1);
    rd(2);
    rd(3);
    apb(1'b0, 8'hB0, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk(32'(last_err), 32'h0000_0001);
    wr(2, 8'hFF);
    foreach (tb[i]) begin
      m = tb[i] >> 12;
      wr(1, {m[1:0], 6'h00});
      wr(0, {m[2], tb[i][8], 2'h3, tb[i][4], tb[i][0], 2'h0});
      cyc(1); // mode output is registered one edge after the write lands
      chk(32'(smode), 32'(m[2:0]));
      per(p);
      per(p);
      chk(32'(p), 32'(exp_p(tb[i])));
    end
    wr(0, 8'h00);
    cyc(2);
    chk(32'(lsb), 32'h0000_0000);
    wr(1, 8'h08);
    wr(2, 8'hFE);
    wr(0, 8'h17);
    cyc(4);
    k = 0;
    j = 0;
    m = 0;
    lc = co;
    repeat (40) begin
      @(posedge clk);
      k += (pt === 1'b1);
      j += (co !== lc);
      m += (bt === 1'b1);
      lc = co;
    end
    chk(32'(k), 32'd20);
    chk(32'(j), 32'd20);
    chk(32'(m), 32'd0);
    chk(32'({sen, oe_n, irq}), 32'h0000_0001);
    mdl[1] = 8'h0A;
    rd(1);
    wr(0, 8'h05);
    wr(3, 8'h40);
    cyc(30);
    rd(3);
    rd(2);
    wr(0, 8'h31);
    repeat (5) begin
      t1 <= 1'b1;
      @(posedge clk);
      t1 <= 1'b0;
      @(posedge clk);
    end
    mdl[3] = 8'h45;
    rd(3);
    wr(2, 8'h77);
    rd(3);
    wr(0, 8'h01);
    wr(2, 8'($urandom()));
    rd(3);
    wr(1, 8'h10);
    want <= 1'b0;
    cyc(8);
    mdl[1] = 8'h11;
    rd(1);
    chk(32'(irq), 32'h0000_0001);
    wr(0, 8'h03);
    cyc(2);
    chk(32'(irq), 32'h0000_0000);
    wr(1, 8'h14);
    want <= 1'b1;
    cyc(8);
    mdl[1] = 8'h15;
    rd(1);
    pdn <= 1'b1;
    ien <= 1'b1;
    wr(0, 8'h01);
    wr(1, 8'h14);
    cyc(6);
    mdl[1] = 8'h15;
    rd(1);
    cyc(2);
    chk(32'(wk), 32'h0000_0001);
    // serial function back on: flags now come from the engine pulses
    wr(0, 8'h20);
    wr(1, 8'h00);
    etx <= 1'b1;
    erx <= 1'b1;
    cyc(1);
    etx <= 1'b0;
    erx <= 1'b0;
    cyc(3);
    mdl[1] = 8'h03;
    rd(1);
    chk(32'(irq), 32'h0000_0001);
    tally_and_finish();
  end

  // watchdog against a hung handshake
  initial begin
    #(40 * 40000);
    err_total++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
